// ==== pcfg_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// - status held low until power-on delay ends
// - completion line low through wait and load
// - data clock ignored after configuration finishes
// - completion released only after full bitstream
// - two falling edges start initialisation
// - init output driven low once option loaded
// - lane widths 1, 8, 16, 32 supported
// - detected error pulls status low, halts chain
// - chained devices wait on wired-AND lines
// - chain output goes low when done
// - enabled device starts within one cycle
// - chain output off unless option set
// - optional global clear and output enable
// - optional user start-up clock for init
// - init output high only in user mode
module pcfg_top #(
	parameter int DATA_W      = 32,
	parameter int POR_COUNT   = pcfg_pkg::POR_CYCLES,
	parameter int INIT_COUNT  = pcfg_pkg::INIT_CYCLES,
	parameter int STREAM_LEN  = pcfg_pkg::STREAM_BITS
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              config_data_clock,
	input  wire logic [DATA_W-1:0] data_lanes,
	input  wire logic [4:0]        scheme_select,
	input  wire logic              config_restart_n,
	input  wire logic              chain_enable_in_n,
	input  wire logic              config_status_in,
	output logic                   config_status_out,
	output logic                   config_status_oe_n,
	input  wire logic              config_complete_in,
	output logic                   config_complete_out,
	output logic                   config_complete_oe_n,
	output logic                   chain_enable_out_n,
	output logic                   chain_enable_out_active,
	output logic                   init_complete,
	output logic                   init_complete_active,
	input  wire logic              user_startup_clock,
	input  wire logic              global_register_clear_n,
	input  wire logic              global_output_enable,
	output logic                   user_mode,
	output logic                   user_reset_n,
	output logic                   user_output_enable,
	output logic                   config_error
);
	import pcfg_pkg::*;

	generate
		if (DATA_W != OPT_W || POR_COUNT < 1 || INIT_COUNT < 1 ||
			STREAM_LEN < OPT_W)
		begin : g_bad
			$error("pcfg_top: unsupported parameter values");
		end
	endgenerate

	typedef struct packed {
		pcfg_state_t state;
		logic [31:0] por_cnt;
		logic [31:0] init_cnt;
		logic [31:0] bits;
		logic [31:0] opt;
		logic [1:0]  width;
		logic        tog_seen, status_low, complete_low, chain_out_n;
		logic        chain_act, init_high, init_act, err, link_run;
		logic        fall_run, uclk_prev, user, user_rst_n, user_oe;
	} pcfg_top_t;

	pcfg_top_t   s;
	pcfg_top_t   next_s;
	logic [1:0]  rst_pipe;
	logic [13:0] sy;
	logic [4:0]  sy_scheme;
	logic [DATA_W-1:0] link_word;
	logic        rst_n, link_tog, link_falls, tick;
	logic        sy_restart_n, sy_ce_n, sy_status, sy_complete, sy_uclk;
	logic        sy_clr_n, sy_oe, sy_tog, sy_falls;

	// every property below runs on the system clock, off during reset
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	function automatic logic [5:0] lane_bits(input logic [1:0] w);
		case (w)
			W_X8:    return BITS_X8;
			W_X16:   return BITS_X16;
			W_SER:   return BITS_SER;
			default: return BITS_X32;
		endcase
	endfunction

	// little-endian packing: the first unit lands in the low bits
	function automatic logic [31:0] shift_in(input logic [31:0] a,
		input logic [31:0] d, input logic [1:0] w);
		case (w)
			W_X8:    return {d[7:0], a[31:8]};
			W_X16:   return {d[15:0], a[31:16]};
			W_SER:   return {d[0], a[31:1]};
			default: return d;
		endcase
	endfunction

	// reset is released through two flops
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	// every control pin and the link toggle and fall levels pass two flops; the lanes and link word do not
	pcfg_sync #(.W(14)) u_sync (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     ({config_restart_n, chain_enable_in_n, config_status_in,
			config_complete_in, user_startup_clock,
			global_register_clear_n, global_output_enable,
			scheme_select, link_tog, link_falls}),
		.q     (sy)
	);
	assign {sy_restart_n, sy_ce_n, sy_status, sy_complete, sy_uclk,
		sy_clr_n, sy_oe, sy_scheme, sy_tog, sy_falls} = sy;
	pcfg_link #(.DATA_W(DATA_W)) u_link (
		.config_data_clock (config_data_clock),
		.capture_run       (s.link_run),
		.fall_run          (s.fall_run),
		.data_lanes        (data_lanes),
		.word              (link_word),
		.word_toggle       (link_tog),
		.falls_seen        (link_falls)
	);
	// start-up tick: user clock edges if chosen, else every cycle
	assign tick = s.opt[OPT_UCLK_BIT] ? (sy_uclk & ~s.uclk_prev) : 1'b1;
	// main sequencer
	always_comb
	begin
		next_s = s;
		next_s.tog_seen  = sy_tog;
		next_s.uclk_prev = sy_uclk;
		case (s.state)
			ST_POR:
			begin
				next_s.por_cnt = s.por_cnt + 32'h1;
				if (s.por_cnt >= 32'(POR_COUNT - 1))
				begin
					next_s.status_low = 1'b0;
					next_s.state      = ST_WAIT;
				end
			end
			ST_HOLD:
				// an own error stays flagged until the host restarts
				if (sy_restart_n && !s.err)
				begin
					next_s.status_low = 1'b0;
					next_s.state      = ST_WAIT;
				end
			ST_WAIT:
			begin
				next_s.width = sy_scheme[1:0];
				// line must read high before loading starts
				if (!sy_ce_n && sy_status)
				begin
					next_s.link_run = 1'b1;
					next_s.state    = ST_LOAD;
				end
			end
			ST_LOAD:
			begin
				next_s.link_run = !sy_ce_n;
				if (s.link_run && sy_tog != s.tog_seen)
				begin
					next_s.bits = s.bits + 32'(lane_bits(s.width));
					if (s.bits < 32'(OPT_W))
						next_s.opt = shift_in(s.opt, link_word, s.width);
					if (next_s.bits >= 32'(STREAM_LEN))
					begin
						next_s.link_run     = 1'b0;
						next_s.complete_low = 1'b0;
						next_s.chain_out_n  = 1'b0;
						next_s.state        = ST_SETTLE;
					end
				end
				// option word complete: check its mark, apply options
				if (s.bits >= 32'(OPT_W) && !s.chain_act && !s.init_act)
				begin
					if (s.opt[31:MARK_LSB] != SYNC_MARK)
					begin
						next_s.err        = 1'b1;
						next_s.status_low = 1'b1;
						next_s.link_run   = 1'b0;
						next_s.state      = ST_HOLD;
					end
					next_s.chain_act = s.opt[OPT_CHAIN_BIT];
					next_s.init_act  = s.opt[OPT_INIT_BIT];
				end
			end
			ST_SETTLE:
				// wired-AND: every chained device must be done
				if (sy_complete)
				begin
					next_s.fall_run = 1'b1;
					next_s.state    = ST_EDGES;
				end
			ST_EDGES:
				if (sy_falls)
				begin
					next_s.fall_run = 1'b0;
					next_s.state    = ST_INIT;
				end
			ST_INIT:
			begin
				if (tick)
					next_s.init_cnt = s.init_cnt + 32'h1;
				if (s.init_cnt >= 32'(INIT_COUNT))
				begin
					next_s.user      = 1'b1;
					next_s.init_high = 1'b1;
					next_s.state     = ST_USER;
				end
			end
			ST_USER:
			begin
				next_s.link_run = 1'b0;
				next_s.fall_run = 1'b0;
			end
			default:
				next_s.state = ST_HOLD;
		endcase
		// someone else on the shared status line flagged an error
		if ((s.state == ST_LOAD || s.state == ST_SETTLE ||
			s.state == ST_EDGES || s.state == ST_INIT) &&
			!sy_status && !s.status_low)
		begin
			next_s.link_run = 1'b0;
			next_s.fall_run = 1'b0;
			next_s.complete_low = 1'b1;
			next_s.state    = ST_HOLD;
		end
		// restart wins over everything once power-on delay is over
		if (!sy_restart_n && s.state != ST_POR)
		begin
			next_s              = '0;
			next_s.state        = ST_HOLD;
			next_s.status_low   = 1'b1;
			next_s.complete_low = 1'b1;
			next_s.chain_out_n  = 1'b1;
			next_s.width        = s.width;
			next_s.tog_seen     = sy_tog;
			next_s.user_rst_n   = 1'b0;
		end
		// optional global pins steer user logic only when enabled
		next_s.user_rst_n = next_s.user &
			(!s.opt[OPT_CLR_BIT] || sy_clr_n);
		next_s.user_oe = next_s.user &
			(!s.opt[OPT_OE_BIT] || sy_oe);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s              <= '0;
			s.state        <= ST_POR;
			s.status_low   <= 1'b1;
			s.complete_low <= 1'b1;
			s.chain_out_n  <= 1'b1;
		end
		else
			s <= next_s;
	end

	// open-drain pins only ever pull low
	assign config_status_out       = 1'b0;
	assign config_status_oe_n      = ~s.status_low;
	assign config_complete_out     = 1'b0;
	assign config_complete_oe_n    = ~s.complete_low;
	assign chain_enable_out_n      = s.chain_out_n;
	assign chain_enable_out_active = s.chain_act;
	assign init_complete           = s.init_high;
	assign init_complete_active    = s.init_act;
	assign user_mode               = s.user;
	assign user_reset_n            = s.user_rst_n;
	assign user_output_enable      = s.user_oe;
	assign config_error            = s.err;

	a_por_hold_low: assert property (
		(s.state == ST_POR) |-> !config_status_oe_n)
		else $error("status released during power-on delay");
	a_complete_low_early: assert property (
		(s.state inside {ST_POR, ST_HOLD, ST_WAIT, ST_LOAD})
		|-> !config_complete_oe_n)
		else $error("completion line released before load end");
	a_done_needs_all: assert property (
		$rose(config_complete_oe_n) |-> s.bits >= 32'(STREAM_LEN))
		else $error("completion released on partial bitstream");
	a_user_ignores_clk: assert property (
		(s.state == ST_USER) |-> ##1 (!s.link_run && !s.fall_run))
		else $error("link logic active in user mode");
	a_two_falls_init: assert property (
		$rose(s.state == ST_INIT) |-> $past(sy_falls))
		else $error("init entered without falling edges");
	a_init_low_opt: assert property (
		init_complete_active |-> (!init_complete || s.state == ST_USER))
		else $error("init output high before user mode");
	a_error_pulls_low: assert property (
		$rose(s.err) |-> !config_status_oe_n && !s.link_run)
		else $error("error did not pull status low");
	a_chain_out_done: assert property (
		$fell(chain_enable_out_n) |-> s.state == ST_SETTLE)
		else $error("chain output low before load done");
	a_chain_start_one: assert property (
		(s.state == ST_WAIT && !sy_ce_n && sy_status && sy_restart_n)
		|=> (s.state == ST_LOAD && s.link_run))
		else $error("enabled device did not start in one cycle");
	a_idle_no_accept: assert property (
		(s.state == ST_LOAD && sy_ce_n) |=> !s.link_run)
		else $error("capture ran with chain enable inactive");
	a_init_high_user: assert property (
		$rose(init_complete) |-> $past(s.state == ST_INIT, 1) && user_mode)
		else $error("init output rose outside start-up");
endmodule
`default_nettype wire

// ==== pcfg_pkg.sv ====
package pcfg_pkg;
	// clock and timing figures
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_TIME_US   = 100;
	localparam int POR_CYCLES    =
		(POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES   = 8192;
	localparam int STREAM_BITS   = 4096;

	// falling edges the host gives after the completion line rises
	localparam logic [1:0] FALL_EDGES = 2'h2;

	// option word: the first 32 stream bits, loaded lsb first
	localparam int OPT_W         = 32;
	localparam int OPT_INIT_BIT  = 0;
	localparam int OPT_CHAIN_BIT = 1;
	localparam int OPT_CLR_BIT   = 2;
	localparam int OPT_OE_BIT    = 3;
	localparam int OPT_UCLK_BIT  = 4;
	localparam int MARK_LSB      = 24;
	localparam logic [7:0] SYNC_MARK = 8'hA5;

	// lane width codes taken from the scheme strap
	localparam logic [1:0] W_X8  = 2'h0;
	localparam logic [1:0] W_X16 = 2'h1;
	localparam logic [1:0] W_X32 = 2'h2;
	localparam logic [1:0] W_SER = 2'h3;
	localparam logic [5:0] BITS_X8  = 6'h08;
	localparam logic [5:0] BITS_X16 = 6'h10;
	localparam logic [5:0] BITS_X32 = 6'h20;
	localparam logic [5:0] BITS_SER = 6'h01;

	typedef enum logic [7:0] {
		ST_POR    = 8'h01,
		ST_HOLD   = 8'h02,
		ST_WAIT   = 8'h04,
		ST_LOAD   = 8'h08,
		ST_SETTLE = 8'h10,
		ST_EDGES  = 8'h20,
		ST_INIT   = 8'h40,
		ST_USER   = 8'h80
	} pcfg_state_t;
endpackage

// ==== pcfg_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcfg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pcfg_sync_t;

	pcfg_sync_t s;
	pcfg_sync_t next_s;

	// first stage feeds only the second stage
	always_comb
	begin
		next_s.meta   = d;
		next_s.stable = s.meta;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.stable;
endmodule
`default_nettype wire

// ==== pcfg_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcfg_link
	import pcfg_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input  wire logic              config_data_clock,
	input  wire logic              capture_run,
	input  wire logic              fall_run,
	input  wire logic [DATA_W-1:0] data_lanes,
	output logic      [DATA_W-1:0] word,
	output logic                   word_toggle,
	output logic                   falls_seen
);
	typedef struct packed {
		logic [DATA_W-1:0] word;
		logic              tog;
	} pcfg_rise_t;

	typedef struct packed {
		logic [1:0] cnt;
		logic       seen;
	} pcfg_fall_t;

	pcfg_rise_t r;
	pcfg_rise_t next_r;
	pcfg_fall_t f;
	pcfg_fall_t next_f;

	// lanes are caught on every rising edge while capture runs; the
	// system side must fetch the word before the next rising edge
	always_comb
	begin
		next_r.word = data_lanes;
		next_r.tog  = ~r.tog;
	end

	// held in clear while idle, so a stopped or loose clock does nothing
	always_ff @(posedge config_data_clock or negedge capture_run)
	begin
		if (!capture_run)
			r <= '0;
		else
			r <= next_r;
	end

	// count falling edges, saturating at the figure needed
	always_comb
	begin
		next_f = f;
		if (f.cnt != FALL_EDGES)
			next_f.cnt = f.cnt + 2'h1;
		next_f.seen = (next_f.cnt == FALL_EDGES);
	end

	always_ff @(negedge config_data_clock or negedge fall_run)
	begin
		if (!fall_run)
			f <= '0;
		else
			f <= next_f;
	end

	assign word        = r.word;
	assign word_toggle = r.tog;
	assign falls_seen  = f.seen;
endmodule
`default_nettype wire

// ==== pcfg_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// host side: it owns the transfer, the device only listens
module pcfg_host (
	output logic        config_data_clock,
	output logic [31:0] data_lanes
);
	// clock parked low between units, never floating
	initial
	begin
		config_data_clock = 1'b0;
		data_lanes        = 32'h0;
	end

	// one unit; lanes settle before the rising edge
	task automatic send_unit(input logic [31:0] d, input int wbits);
		logic [31:0] mask;
		mask = (wbits == 32) ? 32'hFFFFFFFF : ((32'h1 << wbits) - 32'h1);
		// lanes outside the width carry junk the device must ignore
		data_lanes = (d & mask) | ($urandom & ~mask);
		#11 config_data_clock = 1'b1;
		#16 config_data_clock = 1'b0;
		// released lanes stop showing the last value
		data_lanes = ~data_lanes;
		#5;
	endtask

	// the two closing falling edges after completion
	task automatic two_falls();
		repeat (2)
		begin
			#8 config_data_clock = 1'b1;
			#16 config_data_clock = 1'b0;
			#8;
		end
	endtask
endmodule
`default_nettype wire

// ==== pcfg_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcfg_top_tb;
	import pcfg_pkg::*;
	localparam int LEN = 64;
	logic          sys_clk, reset_n, config_restart_n, chain_enable_in_n;
	logic          peer_done, user_startup_clock;
	logic          global_register_clear_n, global_output_enable;
	logic [4:0]    scheme_select, opt;
	logic          config_data_clock;
	logic [31:0]   data_lanes;
	logic          config_status_in, config_status_out, config_status_oe_n;
	logic          config_complete_in, config_complete_out;
	logic          config_complete_oe_n, chain_enable_out_n;
	logic          chain_enable_out_active, init_complete;
	logic          init_complete_active, user_mode, user_reset_n;
	logic          user_output_enable, config_error;
	logic [LEN-1:0] stream;
	logic [31:0]   units[$];
	int            bad_count, num_checks, wb;

	// shared open-drain lines with pull-ups; peer_done models a second device
	// that only holds the completion line low while it is still loading
	assign config_status_in   = config_status_oe_n ? 1'b1 : config_status_out;
	assign config_complete_in =
		(config_complete_oe_n ? 1'b1 : config_complete_out) & peer_done;

	initial
		sys_clk = 1'b0;
	always
		#5 sys_clk = ~sys_clk;

	// start-up clock runs all the time so an enabled option never starves
	always @(negedge sys_clk)
		user_startup_clock <= ~user_startup_clock;

	pcfg_top #(
		.DATA_W     (32),
		.POR_COUNT  (8),
		.INIT_COUNT (4),
		.STREAM_LEN (LEN)
	) pcfg_top_inst (
		.sys_clk                 (sys_clk),
		.reset_n                 (reset_n),
		.config_data_clock       (config_data_clock),
		.data_lanes              (data_lanes),
		.scheme_select           (scheme_select),
		.config_restart_n        (config_restart_n),
		.chain_enable_in_n       (chain_enable_in_n),
		.config_status_in        (config_status_in),
		.config_status_out       (config_status_out),
		.config_status_oe_n      (config_status_oe_n),
		.config_complete_in      (config_complete_in),
		.config_complete_out     (config_complete_out),
		.config_complete_oe_n    (config_complete_oe_n),
		.chain_enable_out_n      (chain_enable_out_n),
		.chain_enable_out_active (chain_enable_out_active),
		.init_complete           (init_complete),
		.init_complete_active    (init_complete_active),
		.user_startup_clock      (user_startup_clock),
		.global_register_clear_n (global_register_clear_n),
		.global_output_enable    (global_output_enable),
		.user_mode               (user_mode),
		.user_reset_n            (user_reset_n),
		.user_output_enable      (user_output_enable),
		.config_error            (config_error)
	);

	pcfg_host pcfg_host_inst (
		.config_data_clock (config_data_clock),
		.data_lanes        (data_lanes)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// model: stream cut into units, little endian, low bits first
	task automatic pack();
		units.delete();
		for (int i = 0; i < LEN; i += wb)
			units.push_back(32'(stream >> i));
	endtask

	task automatic send(input int from, input int upto);
		for (int k = from; k < upto; k++)
			pcfg_host_inst.send_unit(units[k], wb);
	endtask

	// restart pulse held well past the minimum, whole chain restarted
	task automatic restart();
		config_restart_n  = 1'b0;
		chain_enable_in_n = 1'b1;
		cyc(6);
		check(config_complete_oe_n, 1'h0);
		config_restart_n = 1'b1;
		cyc(6);
		check(config_status_oe_n, 1'h1);
		check(config_error, 1'h0);
	endtask

	// one full load at a given width, then start-up and user mode
	task automatic run_load(input logic [1:0] w);
		restart();
		scheme_select = {3'h0, w};
		wb = (w == W_SER) ? 1 : (w == W_X8) ? 8 : (w == W_X16) ? 16 : 32;
		opt = 5'($urandom);
		stream = {$urandom, SYNC_MARK, 19'($urandom), opt};
		pack();
		if (w == W_X8)
		begin
			send(0, units.size());
			cyc(8);
			check(config_complete_oe_n, 1'h0);
		end
		chain_enable_in_n = 1'b0;
		cyc(5);
		send(0, units.size() - 1);
		cyc(8);
		check(config_complete_oe_n, 1'h0);
		check(chain_enable_out_n, 1'h1);
		// a peer still loading keeps the shared line low
		peer_done = 1'b0;
		send(units.size() - 1, units.size());
		cyc(8);
		check(config_complete_oe_n, 1'h1);
		check(chain_enable_out_n, 1'h0);
		check(chain_enable_out_active, opt[1]);
		check(init_complete_active, opt[0]);
		check(init_complete, 1'h0);
		pcfg_host_inst.two_falls();
		cyc(20);
		check(user_mode, 1'h0);
		peer_done = 1'b1;
		cyc(4);
		pcfg_host_inst.two_falls();
		for (int i = 0; i < 300 && user_mode !== 1'b1; i++)
			cyc(1);
		check(user_mode, 1'h1);
		check(init_complete, 1'h1);
		// late data clock edges must change nothing
		send(0, 3);
		cyc(8);
		check(user_mode, 1'h1);
		check(config_complete_oe_n, 1'h1);
		global_register_clear_n = 1'b0;
		global_output_enable    = 1'b0;
		cyc(6);
		check(user_reset_n, !opt[2]);
		check(user_output_enable, !opt[3]);
		global_register_clear_n = 1'b1;
		global_output_enable    = 1'b1;
		$display("test width %0d done", wb);
	endtask

	// stimulus at falling edges; reset held 8 cycles
	initial
	begin
		reset_n                 = 1'b0;
		config_restart_n        = 1'b1;
		chain_enable_in_n       = 1'b1;
		peer_done               = 1'b1;
		user_startup_clock      = 1'b0;
		global_register_clear_n = 1'b1;
		global_output_enable    = 1'b1;
		scheme_select           = 5'h02;
		bad_count               = 0;
		num_checks              = 0;
		void'($urandom(79449));
		cyc(8);
		check(config_status_oe_n, 1'h0);
		check(config_complete_oe_n, 1'h0);
		check(chain_enable_out_n, 1'h1);
		reset_n = 1'b1;
		cyc(4);
		check(config_status_oe_n, 1'h0);
		cyc(20);
		check(config_status_oe_n, 1'h1);
		$display("test reset done");
		for (int w = 0; w < 4; w++)
			run_load(2'(w));
		// corrupt sync mark must flag an error on the shared line
		restart();
		scheme_select = {3'h0, W_X32};
		wb = 32;
		stream = {$urandom, 8'h5A, 24'($urandom)};
		pack();
		chain_enable_in_n = 1'b0;
		cyc(5);
		send(0, units.size());
		cyc(8);
		check(config_error, 1'h1);
		check(config_status_oe_n, 1'h0);
		check(config_complete_oe_n, 1'h0);
		restart();
		$display("test error done");
		end_sim();
	end

	// watchdog well past the expected run length
	initial
	begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
